//--- rtl/fsc_pkg.sv
// Package: constants, offsets and types for the seek/recalibrate/interrupt-status block
package fsc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CMD        = 4'h0;  // W: command opcode starts command
  localparam logic [3:0] OFF_TARGET     = 4'h1;  // RW: target cylinder for seek
  localparam logic [3:0] OFF_STEP_RATE  = 4'h2;  // RW: step-rate setting
  localparam logic [3:0] OFF_STATUS     = 4'h3;  // R: main status (busy, pending)
  localparam logic [3:0] OFF_ST0        = 4'h4;  // R: status_zero of last sense
  localparam logic [3:0] OFF_PCYL       = 4'h5;  // R: present cylinder
  localparam logic [3:0] OFF_ID_C       = 4'h6;  // R: captured id cylinder
  localparam logic [3:0] OFF_ID_H       = 4'h7;  // R: captured id head
  localparam logic [3:0] OFF_ID_R       = 4'h8;  // R: captured id sector
  localparam logic [3:0] OFF_ID_N       = 4'h9;  // R: captured id size
  localparam logic [3:0] OFF_ST1        = 4'hA;  // R: status one (missing mark)
  localparam logic [3:0] OFF_ST3        = 4'hB;  // R: drive status (sense drive)
  localparam logic [3:0] OFF_FMT        = 4'hC;  // R: single-density gap 4a length
  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RECAL      = 8'h07;
  localparam logic [7:0] CMD_SENSE_INT  = 8'h08;
  localparam logic [7:0] CMD_SEEK       = 8'h0F;
  localparam logic [7:0] CMD_SENSE_DRV  = 8'h04;
  localparam logic [7:0] CMD_READ_ID    = 8'h0A;
  localparam logic [7:0] CMD_WAKE       = 8'h1F;  // Leave low-power state
  // ----------------------------------------------------------------
  // status_zero and status one fields
  // ----------------------------------------------------------------
  localparam int ST0_IC_LSB = 6;
  localparam int ST0_SE_BIT = 5;
  localparam int ST0_EC_BIT = 4;
  localparam int ST0_H_BIT  = 2;
  localparam int ST1_MA_BIT = 0;
  localparam logic [1:0] IC_NORMAL   = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL     = 2'h3;
  // ----------------------------------------------------------------
  // Counts and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] RECAL_MAX_STEPS = 7'd79;
  localparam int         CLK_HZ          = 20_000_000;
  localparam int         STEP_PULSE_NS   = 1000;      // Width of one step pulse
  localparam int         STEP_PULSE_CYC  = (STEP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int         SRT_UNIT_CYC    = 10;        // Cycles per step-rate unit
  localparam logic [3:0] STEP_RATE_RST   = 4'h8;
  // Single-density track format figures
  localparam logic [7:0] FMT_GAP4A_LEN = 8'd40;
  localparam logic [7:0] FMT_SYNC_LEN  = 8'd6;
  localparam logic [7:0] FMT_GAP1_LEN  = 8'd26;
  localparam logic [7:0] FMT_GAP2_LEN  = 8'd11;
  localparam logic [7:0] FMT_IAM       = 8'hFC;
  localparam logic [7:0] FMT_ID_ADDRESS_MARK      = 8'hFE;
  localparam logic [7:0] FMT_DAM       = 8'hFB;
  localparam logic [7:0] FMT_DDAM      = 8'hF8;
  localparam logic [7:0] FMT_GAP_FILL  = 8'hFF;
  localparam logic [7:0] FMT_SYNC_FILL = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DIR   = 3'b001,
    ST_PULSE = 3'b010,
    ST_WAIT  = 3'b011,
    ST_RDID  = 3'b100
  } fsc_state_t;
endpackage

//--- rtl/fsc_ctrl.sv
// Control-command logic: seek, recalibrate, read id, interrupt and drive status
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fsc_ctrl #(
  parameter int SRT_W = 4
) (
  input  wire logic       clk,          // 20 MHz clock
  input  wire logic       rst_n,        // Synchronous reset, active low
  input  wire logic [3:0] addr,         // Register index
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output logic      [7:0] rdata,        // Read data, cycle after rd
  input  wire logic       track_zero_n, // Drive track-zero pin
  input  wire logic       index_pulse_n,// Drive index pin
  input  wire logic       id_valid,     // Separator: good id field, same clock
  input  wire logic [7:0] id_cyl,       // Id cylinder
  input  wire logic [7:0] id_head,      // Id head
  input  wire logic [7:0] id_sec,       // Id sector
  input  wire logic [7:0] id_size,      // Id size
  input  wire logic       xfer_req,     // Non-DMA transfer need, same clock
  input  wire logic       result_enter, // Data command enters result, same clock
  output logic            step,         // Step pulse to drive
  output logic            dir,          // Step direction, 1 = in
  output logic            irq           // Interrupt output
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tz_s1_reg, tz_s2_reg, ix_s1_reg, ix_s2_reg, ix_s3_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tz_s1_reg <= 1'b0;
      tz_s2_reg <= 1'b0;
      ix_s1_reg <= 1'b1;
      ix_s2_reg <= 1'b1;
      ix_s3_reg <= 1'b1;
    end else begin
      tz_s1_reg <= track_zero_n;
      tz_s2_reg <= tz_s1_reg;
      ix_s1_reg <= index_pulse_n;
      ix_s2_reg <= ix_s1_reg;
      ix_s3_reg <= ix_s2_reg;
    end
  end
  logic index_fall;
  assign index_fall = ix_s3_reg & ~ix_s2_reg;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic cmd_wr;
  assign cmd_wr = wr && (addr == fsc_pkg::OFF_CMD);

  fsc_pkg::fsc_state_t state_reg;
  logic [7:0]  pcyl_reg, target_reg;
  logic [SRT_W-1:0] srt_reg;
  logic        recal_reg, first_reg, busy_reg, pend_reg, pos_busy_reg;
  logic [6:0]  nstep_reg;
  logic [15:0] tmr_reg;
  logic [1:0]  nidx_reg;
  logic [7:0]  st0_reg, st1_reg, st3_reg;
  logic [7:0]  idc_reg, idh_reg, idr_reg, idn_reg;
  // Cause latched at completion, reported by sense interrupt
  logic        cause_se_reg, cause_ec_reg;
  logic [1:0]  cause_ic_reg;
  logic        done_pos, done_ok, done_ec, rdid_done, rdid_fail;

  logic idle;
  assign idle = (state_reg == fsc_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Step-rate setting and target
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srt_reg    <= SRT_W'(fsc_pkg::STEP_RATE_RST);
      target_reg <= 8'h00;
    end else begin
      if (wr && addr == fsc_pkg::OFF_STEP_RATE) srt_reg <= wdata[SRT_W-1:0];
      if (wr && addr == fsc_pkg::OFF_TARGET) target_reg <= wdata;
    end
  end

  // Larger setting gives shorter spacing, as usual for step-rate codes
  logic [15:0] step_gap;
  assign step_gap = 16'((({SRT_W{1'b1}} - srt_reg) + 1) * fsc_pkg::SRT_UNIT_CYC);

  // ----------------------------------------------------------------
  // Positioning sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= fsc_pkg::ST_IDLE;
      pcyl_reg  <= 8'h00;
      recal_reg <= 1'b0;
      first_reg <= 1'b0;
      nstep_reg <= 7'd0;
      tmr_reg   <= 16'h0000;
      step      <= 1'b0;
      dir       <= 1'b0;
      nidx_reg  <= 2'd0;
    end else begin
      case (state_reg)
        fsc_pkg::ST_IDLE: begin
          step <= 1'b0;
          if (cmd_wr && wdata == fsc_pkg::CMD_WAKE) pcyl_reg <= 8'h00;
          if (cmd_wr && wdata == fsc_pkg::CMD_RECAL) begin
            pcyl_reg  <= 8'h00;
            recal_reg <= 1'b1;
            nstep_reg <= 7'd0;
            first_reg <= 1'b1;
            dir       <= 1'b0;
            state_reg <= fsc_pkg::ST_DIR;
          end else if (cmd_wr && wdata == fsc_pkg::CMD_SEEK) begin
            recal_reg <= 1'b0;
            first_reg <= 1'b1;
            dir       <= (pcyl_reg < target_reg);
            state_reg <= fsc_pkg::ST_DIR;
          end else if (cmd_wr && wdata == fsc_pkg::CMD_READ_ID) begin
            nidx_reg  <= 2'd0;
            state_reg <= fsc_pkg::ST_RDID;
          end
        end
        fsc_pkg::ST_DIR: begin
          if (recal_reg && tz_s2_reg) begin
            state_reg <= fsc_pkg::ST_IDLE;
          end else if (recal_reg && nstep_reg == fsc_pkg::RECAL_MAX_STEPS) begin
            state_reg <= fsc_pkg::ST_IDLE;
          end else if (!recal_reg && pcyl_reg == target_reg) begin
            state_reg <= fsc_pkg::ST_IDLE;
          end else begin
            step      <= 1'b1;
            tmr_reg   <= 16'(fsc_pkg::STEP_PULSE_CYC);
            state_reg <= fsc_pkg::ST_PULSE;
          end
        end
        fsc_pkg::ST_PULSE: begin
          if (tmr_reg <= 16'd1) begin
            step      <= 1'b0;
            nstep_reg <= nstep_reg + 7'd1;
            if (!recal_reg) pcyl_reg <= dir ? pcyl_reg + 8'd1 : pcyl_reg - 8'd1;
            tmr_reg   <= first_reg ? (step_gap >> 1) : step_gap;
            first_reg <= 1'b0;
            state_reg <= fsc_pkg::ST_WAIT;
          end else begin
            tmr_reg <= tmr_reg - 16'd1;
          end
        end
        fsc_pkg::ST_WAIT: begin
          if (tmr_reg <= 16'd1) state_reg <= fsc_pkg::ST_DIR;
          else tmr_reg <= tmr_reg - 16'd1;
        end
        fsc_pkg::ST_RDID: begin
          if (index_fall) nidx_reg <= nidx_reg + 2'd1;
          if (id_valid) state_reg <= fsc_pkg::ST_IDLE;
          else if (index_fall && nidx_reg == 2'd1) state_reg <= fsc_pkg::ST_IDLE;
        end
        default: state_reg <= fsc_pkg::ST_IDLE;
      endcase
    end
  end

  assign done_pos = (state_reg == fsc_pkg::ST_DIR) &&
                    ((recal_reg && (tz_s2_reg || nstep_reg == fsc_pkg::RECAL_MAX_STEPS)) ||
                     (!recal_reg && pcyl_reg == target_reg));
  assign done_ec   = recal_reg && !tz_s2_reg;
  assign done_ok   = !done_ec;
  assign rdid_done = (state_reg == fsc_pkg::ST_RDID) && id_valid;
  assign rdid_fail = (state_reg == fsc_pkg::ST_RDID) && !id_valid && index_fall &&
                     (nidx_reg == 2'd1);

  // ----------------------------------------------------------------
  // Read id capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idc_reg <= 8'h00;
      idh_reg <= 8'h00;
      idr_reg <= 8'h00;
      idn_reg <= 8'h00;
    end else if (rdid_done) begin
      idc_reg <= id_cyl;
      idh_reg <= id_head;
      idr_reg <= id_sec;
      idn_reg <= id_size;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt, busy and status
  // ----------------------------------------------------------------
  logic sense_int, sense_drv, wake;
  assign sense_int = cmd_wr && wdata == fsc_pkg::CMD_SENSE_INT;
  assign sense_drv = cmd_wr && wdata == fsc_pkg::CMD_SENSE_DRV;
  assign wake      = cmd_wr && wdata == fsc_pkg::CMD_WAKE;

  logic raise;
  assign raise = done_pos || rdid_done || rdid_fail || result_enter || xfer_req;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg     <= 1'b0;
      irq          <= 1'b0;
      pos_busy_reg <= 1'b0;
      cause_se_reg <= 1'b0;
      cause_ec_reg <= 1'b0;
      cause_ic_reg <= fsc_pkg::IC_POLL;
      st0_reg      <= 8'h00;
      st1_reg      <= 8'h00;
      st3_reg      <= 8'h00;
    end else begin
      if (raise) begin
        pend_reg <= 1'b1;
        irq      <= 1'b1;
      end else if (sense_int || wake) begin
        pend_reg <= 1'b0;
        irq      <= 1'b0;
      end
      if (cmd_wr && (wdata == fsc_pkg::CMD_SEEK || wdata == fsc_pkg::CMD_RECAL))
        pos_busy_reg <= 1'b1;
      else if (sense_int || wake)
        pos_busy_reg <= 1'b0;
      if (done_pos) begin
        cause_se_reg <= 1'b1;
        cause_ec_reg <= done_ec;
        cause_ic_reg <= done_ok ? fsc_pkg::IC_NORMAL : fsc_pkg::IC_ABNORMAL;
      end else if (rdid_fail) begin
        cause_se_reg <= 1'b0;
        cause_ec_reg <= 1'b0;
        cause_ic_reg <= fsc_pkg::IC_ABNORMAL;
        st1_reg[fsc_pkg::ST1_MA_BIT] <= 1'b1;
      end else if (sense_int) begin
        cause_se_reg <= 1'b0;
        cause_ec_reg <= 1'b0;
        cause_ic_reg <= fsc_pkg::IC_POLL;
      end
      if (sense_int) begin
        st0_reg <= 8'(({6'h00, cause_ic_reg} << fsc_pkg::ST0_IC_LSB) |
                      ({7'h00, cause_se_reg} << fsc_pkg::ST0_SE_BIT) |
                      ({7'h00, cause_ec_reg} << fsc_pkg::ST0_EC_BIT));
      end
      if (rdid_done) st1_reg <= 8'h00;
      if (sense_drv) st3_reg <= {3'b000, tz_s2_reg, 4'h0};
      if (wake) begin
        st0_reg <= 8'h00;
        st1_reg <= 8'h00;
        st3_reg <= 8'h00;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) busy_reg <= 1'b0;
    else        busy_reg <= cmd_wr;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        fsc_pkg::OFF_STEP_RATE: rdata <= 8'(srt_reg);
        fsc_pkg::OFF_TARGET:    rdata <= target_reg;
        fsc_pkg::OFF_STATUS:    rdata <= {4'h0, (state_reg == fsc_pkg::ST_RDID),
                                          pos_busy_reg, pend_reg, busy_reg};
        fsc_pkg::OFF_ST0:       rdata <= st0_reg;
        fsc_pkg::OFF_PCYL:      rdata <= pcyl_reg;
        fsc_pkg::OFF_ID_C:      rdata <= idc_reg;
        fsc_pkg::OFF_ID_H:      rdata <= idh_reg;
        fsc_pkg::OFF_ID_R:      rdata <= idr_reg;
        fsc_pkg::OFF_ID_N:      rdata <= idn_reg;
        fsc_pkg::OFF_ST1:       rdata <= st1_reg;
        fsc_pkg::OFF_ST3:       rdata <= st3_reg;
        fsc_pkg::OFF_FMT:       rdata <= fsc_pkg::FMT_GAP4A_LEN;
        default:                rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_dir_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg != fsc_pkg::ST_IDLE && state_reg != fsc_pkg::ST_RDID) |=> $stable(dir)
      or $past(state_reg == fsc_pkg::ST_IDLE)) else $error("dir moved while stepping");
  a_seek_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && cmd_wr && wdata == fsc_pkg::CMD_SEEK) |=> dir == ($past(pcyl_reg) < target_reg))
    else $error("seek direction wrong");
  a_recal_out: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && cmd_wr && wdata == fsc_pkg::CMD_RECAL) |=> (!dir && pcyl_reg == 8'h00))
    else $error("recal not stepping out");
  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    raise |=> irq) else $error("interrupt not raised");
  a_sense_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (sense_int && !raise) |=> !irq) else $error("sense did not clear");
  a_head_zero: assert property (@(posedge clk) disable iff (!rst_n)
    st0_reg[fsc_pkg::ST0_H_BIT] == 1'b0) else $error("head bit set");
  a_recal_lim: assert property (@(posedge clk) disable iff (!rst_n)
    recal_reg |-> nstep_reg <= fsc_pkg::RECAL_MAX_STEPS) else $error("too many steps");
  a_busy_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    busy_reg |-> $past(cmd_wr)) else $error("busy outside command");
  a_rdid_fail: assert property (@(posedge clk) disable iff (!rst_n)
    rdid_fail |=> (st1_reg[fsc_pkg::ST1_MA_BIT] && cause_ic_reg == fsc_pkg::IC_ABNORMAL))
    else $error("missing mark not flagged");
  c_seek: cover property (@(posedge clk) disable iff (!rst_n) done_pos && !recal_reg);
  c_recal_ec: cover property (@(posedge clk) disable iff (!rst_n) done_pos && done_ec);
  c_rdid: cover property (@(posedge clk) disable iff (!rst_n) rdid_done);
  c_sense: cover property (@(posedge clk) disable iff (!rst_n) sense_int && pend_reg);
endmodule
`default_nettype wire

//--- sim/fsc_drive_model.sv
// Behavioural disk drive: head position, track-zero and index pins
`timescale 1ns/10ps
`default_nettype none
module fsc_drive_model #(
  parameter int START_POS    = 3,
  parameter int INDEX_PERIOD = 200
) (
  input  wire logic       clk,           // Controller clock
  input  wire logic       rst_n,         // Synchronous reset, active low
  input  wire logic       step,          // Step pulse from controller
  input  wire logic       dir,           // Direction, 1 = in
  input  wire logic       stuck,         // Fault: track-zero sensor never reports
  input  wire logic       spin,          // Disk turning, index pulses run
  output logic            track_zero_n,  // High at track 0
  output logic            index_pulse_n, // Active-low index pulse
  output logic      [7:0] steps          // Step pulses seen
);
  logic step_q;
  int   pos;
  int   tick;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos    <= START_POS;
      steps  <= 8'h00;
      step_q <= 1'b0;
    end else begin
      step_q <= step;
      // Head moves one track per step pulse; stops mechanically at 0
      if (step && !step_q) begin
        steps <= steps + 8'h01;
        if (dir) pos <= pos + 1;
        else if (pos > 0) pos <= pos - 1;
      end
    end
  end
  assign track_zero_n = (pos == 0) && !stuck;
  // Index only while spinning, so a stopped disk shows no pulses
  always_ff @(posedge clk) begin
    tick          <= (tick >= INDEX_PERIOD - 1) ? 0 : tick + 1;
    index_pulse_n <= !(spin && tick < 4);
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the seek, recalibrate and interrupt-status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       track_zero_n;
  logic       index_pulse_n;
  logic       id_valid = 1'b0;
  logic [7:0] id_cyl = 8'h00;
  logic [7:0] id_head = 8'h00;
  logic [7:0] id_sec = 8'h00;
  logic [7:0] id_size = 8'h00;
  logic       xfer_req = 1'b0;
  logic       result_enter = 1'b0;
  logic       step;
  logic       dir;
  logic       irq;
  logic       stuck = 1'b0;
  logic       spin = 1'b0;
  logic [7:0] steps;
  int         errors = 0;
  int         comparisons = 0;
  logic [7:0] got;

  always #25 clk = ~clk;

  fsc_ctrl fsc_ctrl_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .track_zero_n(track_zero_n), .index_pulse_n(index_pulse_n),
    .id_valid(id_valid), .id_cyl(id_cyl), .id_head(id_head), .id_sec(id_sec),
    .id_size(id_size), .xfer_req(xfer_req), .result_enter(result_enter), .step(step),
    .dir(dir), .irq(irq));
  fsc_drive_model fsc_drive_model_i (.clk(clk), .rst_n(rst_n), .step(step), .dir(dir),
    .stuck(stuck), .spin(spin), .track_zero_n(track_zero_n),
    .index_pulse_n(index_pulse_n), .steps(steps));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1 `CHK(irq, 1'b1)
  endtask
  // Sense interrupt, then status_zero must equal exp and the line must drop
  task automatic sense(input logic [7:0] exp);
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_SENSE_INT);
    repeat (2) @(posedge clk);
    rd_reg(fsc_pkg::OFF_ST0);
    `CHK(got, exp)
    `CHK(irq, 1'b0)
  endtask
  // One positioning command with its full follow-up
  task automatic position(input logic [7:0] cmd, input logic [7:0] tgt, input logic edir,
                          input logic [7:0] nst, input logic [7:0] st0, input logic [7:0] pc);
    logic [7:0] s0;
    s0 = steps;
    wr_reg(fsc_pkg::OFF_TARGET, tgt);
    wr_reg(fsc_pkg::OFF_CMD, cmd);
    repeat (2) @(posedge clk);
    #1 `CHK(dir, edir)
    rd_reg(fsc_pkg::OFF_STATUS);
    `CHK(got & 8'h05, 8'h04)
    wait_irq(5000);
    `CHK(dir, edir)
    rd_reg(fsc_pkg::OFF_STATUS);
    `CHK(got & 8'h06, 8'h06)
    `CHK(steps - s0, nst)
    sense(st0);
    rd_reg(fsc_pkg::OFF_PCYL);
    `CHK(got, pc)
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CHK(irq, 1'b0)
    rd_reg(fsc_pkg::OFF_STEP_RATE);
    `CHK(got, {4'h0, fsc_pkg::STEP_RATE_RST})
    rd_reg(4'hD);
    `CHK(got, 8'h00)
    rd_reg(fsc_pkg::OFF_FMT);
    `CHK(got, fsc_pkg::FMT_GAP4A_LEN)
    wr_reg(fsc_pkg::OFF_STEP_RATE, 8'h0F);
    rd_reg(fsc_pkg::OFF_STEP_RATE);
    `CHK(got, 8'h0F)
    // Power-up recalibrate from track 3, normal end
    position(fsc_pkg::CMD_RECAL, 8'h00, 1'b0, 8'h03, 8'h20, 8'h00);
    position(fsc_pkg::CMD_SEEK, 8'h05, 1'b1, 8'h05, 8'h20, 8'h05);
    position(fsc_pkg::CMD_SEEK, 8'h02, 1'b0, 8'h03, 8'h20, 8'h02);
    sense(8'hC0);
    // Sensor stuck: full count then equipment check
    stuck <= 1'b1;
    position(fsc_pkg::CMD_RECAL, 8'h00, 1'b0, 8'd79, 8'h70, 8'h00);
    stuck <= 1'b0;
    // Read ID takes the first good field only
    // no data command issued, so no gap length is sent
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_READ_ID);
    repeat (5) @(posedge clk);
    {id_cyl, id_head, id_sec, id_size} <= 32'h2101_0702;
    id_valid <= 1'b1;
    @(posedge clk);
    {id_cyl, id_head, id_sec, id_size} <= 32'h5501_0903;
    @(posedge clk);
    id_valid <= 1'b0;
    wait_irq(100);
    rd_reg(fsc_pkg::OFF_ID_C);
    `CHK(got, 8'h21)
    rd_reg(fsc_pkg::OFF_ID_H);
    `CHK(got, 8'h01)
    rd_reg(fsc_pkg::OFF_ID_R);
    `CHK(got, 8'h07)
    rd_reg(fsc_pkg::OFF_ID_N);
    `CHK(got, 8'h02)
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_SENSE_INT);
    // No mark found: ends after two index pulses
    spin <= 1'b1;
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_READ_ID);
    wait_irq(1000);
    spin <= 1'b0;
    rd_reg(fsc_pkg::OFF_ST1);
    `CHK(got & 8'h01, 8'h01)
    sense(8'h40);
    // Other interrupt sources
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      xfer_req     <= (k == 0);
      result_enter <= (k == 1);
      @(posedge clk);
      xfer_req     <= 1'b0;
      result_enter <= 1'b0;
      wait_irq(10);
      wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_SENSE_INT);
      repeat (3) @(posedge clk);
      #1 `CHK(irq, 1'b0)
    end
    // Drive status straight to result, no interrupt
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_SENSE_DRV);
    rd_reg(fsc_pkg::OFF_ST3);
    `CHK(got & 8'h10, 8'h10)
    repeat (20) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    // Move off track 0, then wake clears cylinder and status
    position(fsc_pkg::CMD_SEEK, 8'h04, 1'b1, 8'h04, 8'h20, 8'h04);
    wr_reg(fsc_pkg::OFF_CMD, fsc_pkg::CMD_WAKE);
    repeat (3) @(posedge clk);
    rd_reg(fsc_pkg::OFF_PCYL);
    `CHK(got, 8'h00)
    rd_reg(fsc_pkg::OFF_ST0);
    `CHK(got, 8'h00)
    wrap_up();
  end
endmodule
`default_nettype wire
